// ===== core/base_address_decoder.sv
// Contract
// - Qualifier high means memory, low means I/O
// - Memory spans A0-A19, I/O spans A0-A15
// - Switch terminals select both base locations
// - Outputs are memory and I/O chip selects
// - I/O select uses I/O code and address
// - I/O codes 0-6 match 00-06; 7 never
// - Memory select uses memory code and address
// - Memory codes 0-4 match 18-38; 5-7 never
// - Base values are replaceable example tables
// - Boot window has five places or disabled
`timescale 1ns/1ps
`default_nettype none

module base_address_decoder (
  input  wire logic                                   clk_i,
  input  wire logic                                   sys_rst_i,
  input  wire logic                                   ce_i,
  input  wire logic [base_decode_pkg::MEM_ADDR_W-1:0] addr_i,
  input  wire logic                                   mem_cycle_i,
  input  wire base_decode_pkg::switch_s               switch_i,
  output logic                                        io_sel_o,
  output logic                                        mem_sel_o,
  input  wire logic [11:0]                            s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [31:0]                            s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  input  wire logic [11:0]                            s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [31:0]                                 s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [base_decode_pkg::DEC_W-1:0]     dec_addr;
  logic [base_decode_pkg::IO_ADDR_W-1:0] io_addr;
  logic [base_decode_pkg::NUM_CODES-1:0] io_hit;
  logic [base_decode_pkg::NUM_CODES-1:0] mem_hit;
  logic [1:0]                            ctrl_q;
  logic [1:0]                            ctrl_d;

  assign io_addr  = addr_i[base_decode_pkg::IO_ADDR_W-1:0];
  assign dec_addr = io_addr[base_decode_pkg::DEC_W-1:0];

  for (genvar k = 0; k < base_decode_pkg::NUM_CODES; k++) begin : g_code
    // Per-code match against the base tables
    localparam int unsigned CODE_IDX = k;
    assign io_hit[k]  = base_decode_pkg::IO_CODE_EN[k]
                        && (switch_i.io_code == CODE_IDX[base_decode_pkg::CODE_W-1:0])
                        && (dec_addr == base_decode_pkg::IO_BASE_TBL[k*6 +: 6]);
    assign mem_hit[k] = base_decode_pkg::MEM_CODE_EN[k]
                        && (switch_i.mem_code == CODE_IDX[base_decode_pkg::CODE_W-1:0])
                        && (dec_addr == base_decode_pkg::MEM_BASE_TBL[k*6 +: 6]);
  end

  always_comb begin
    io_sel_o  = ctrl_q[base_decode_pkg::CTRL_IO_EN] && !mem_cycle_i && (|io_hit);
    mem_sel_o = ctrl_q[base_decode_pkg::CTRL_MEM_EN] && mem_cycle_i && (|mem_hit);
  end

  // ------------------------------------------------------------
  // Register bus, write side
  // ------------------------------------------------------------
  logic        aw_got_q;
  logic        aw_got_d;
  logic        w_got_q;
  logic        w_got_d;
  logic [11:0] awaddr_q;
  logic [11:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        aw_hs;
  logic        w_hs;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  assign s_axi_awready = ce_i && !aw_got_q && !bvalid_q;
  assign s_axi_wready  = ce_i && !w_got_q && !bvalid_q;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctrl_d   = ctrl_q;
    wr_addr  = aw_got_q ? awaddr_q : s_axi_awaddr;
    wr_data  = w_got_q ? wdata_q : s_axi_wdata;
    wr_strb  = w_got_q ? wstrb_q : s_axi_wstrb;
    if (aw_hs) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (w_hs) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if ((aw_got_q || aw_hs) && (w_got_q || w_hs)) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      case ({wr_addr[11:2], 2'b00})
        base_decode_pkg::CTRL_OFFS: begin
          bresp_d = base_decode_pkg::RESP_OKAY;
          if (wr_strb[0]) begin
            ctrl_d = wr_data[1:0];
          end
        end
        base_decode_pkg::STATUS_OFFS,
        base_decode_pkg::SWITCH_OFFS: begin
          bresp_d = base_decode_pkg::RESP_OKAY;
        end
        default: begin
          bresp_d = base_decode_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= base_decode_pkg::RESP_OKAY;
      ctrl_q   <= base_decode_pkg::CTRL_RESET;
    end else if (ce_i) begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Register bus, read side
  // ------------------------------------------------------------
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic        ar_hs;

  assign s_axi_arready = ce_i && !rvalid_q;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d  = base_decode_pkg::RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        base_decode_pkg::CTRL_OFFS:   rdata_d = {30'h0000_0000, ctrl_q};
        base_decode_pkg::STATUS_OFFS: rdata_d = {29'h0000_0000, mem_cycle_i, mem_sel_o, io_sel_o};
        base_decode_pkg::SWITCH_OFFS: rdata_d = {26'h000_0000, switch_i};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = base_decode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= base_decode_pkg::RESP_OKAY;
    end else if (ce_i) begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  io_excl_a: assert property (mem_cycle_i |-> !io_sel_o)
    else $error("I/O select active in a memory cycle");
  mem_excl_a: assert property (!mem_cycle_i |-> !mem_sel_o)
    else $error("Memory select active in an I/O cycle");
  io_code_off_a: assert property (switch_i.io_code == 3'h7 |-> !io_sel_o)
    else $error("I/O select active for code 7");
  mem_code_off_a: assert property (switch_i.mem_code >= 3'h5 |-> !mem_sel_o)
    else $error("Memory select active for a disabled code");
  io_match_a: assert property (ctrl_q[0] && !mem_cycle_i && switch_i.io_code != 3'h7
      && addr_i[5:0] == {3'h0, switch_i.io_code} |-> io_sel_o)
    else $error("I/O select missing on a matching address");
  mem_match_a: assert property (ctrl_q[1] && mem_cycle_i && switch_i.mem_code < 3'h5
      && addr_i[5:0] == 6'h18 + {switch_i.mem_code, 3'h0} |-> mem_sel_o)
    else $error("Memory select missing on a matching address");
  io_range_a: assert property (io_sel_o |-> addr_i[5:3] == 3'h0 && addr_i[2:0] == switch_i.io_code)
    else $error("I/O select outside its base");
  mem_range_a: assert property (mem_sel_o |-> addr_i[2:0] == 3'h0
      && addr_i[5:3] == switch_i.mem_code + 3'h3)
    else $error("Memory select outside its base");
  sel_follow_a: assert property (ctrl_q == 2'h3 && $changed(switch_i.io_code) && !mem_cycle_i
      && addr_i[5:0] == {3'h0, switch_i.io_code} && switch_i.io_code != 3'h7 |-> io_sel_o)
    else $error("I/O select did not follow a switch change");
  sel_excl_a: assert property (!(io_sel_o && mem_sel_o))
    else $error("Both selects active together");
  io_gate_a: assert property (!ctrl_q[base_decode_pkg::CTRL_IO_EN] |-> !io_sel_o)
    else $error("I/O select active while disabled");
  mem_gate_a: assert property (!ctrl_q[base_decode_pkg::CTRL_MEM_EN] |-> !mem_sel_o)
    else $error("Memory select active while disabled");
  io_base_a: assert property (io_sel_o |-> addr_i[5:0] <= 6'h06)
    else $error("I/O select above the highest base");
  mem_base_a: assert property (mem_sel_o |-> addr_i[5:0] inside {6'h18, 6'h20, 6'h28, 6'h30, 6'h38})
    else $error("Memory select away from the five bases");

  // ------------------------------------------------------------
  // Register bus checks
  // ------------------------------------------------------------
  aw_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write channels ready while a response is pending");
  ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address ready while read data is pending");
  ready_ce_a: assert property (!ce_i |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("Bus ready while the clock enable is low");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before it was taken");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped before it was taken");
  b_answer_a: assert property ((aw_got_q || aw_hs) && (w_got_q || w_hs)
      |=> s_axi_bvalid)
    else $error("Write response missing after both channels");
  r_answer_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("Read data missing after the address");
  freeze_a: assert property (!ce_i
      |=> $stable(ctrl_q) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("State moved while the clock enable was low");
  wr_ctrl_a: assert property ((aw_got_q || aw_hs) && (w_got_q || w_hs) && wr_addr[11:2] == 10'h000
      && wr_strb[0] |=> ctrl_q == $past(wr_data[1:0]))
    else $error("Control write did not land");
  wr_slverr_a: assert property ((aw_got_q || aw_hs) && (w_got_q || w_hs) && wr_addr[11:2] > 10'h002
      |=> s_axi_bresp == base_decode_pkg::RESP_SLVERR)
    else $error("Unmapped write not answered with an error");
  rd_mapped_a: assert property (ar_hs && s_axi_araddr[11:2] <= 10'h002
      |=> s_axi_rresp == base_decode_pkg::RESP_OKAY)
    else $error("Mapped read not answered with okay");
  rd_unmapped_a: assert property (ar_hs && s_axi_araddr[11:2] > 10'h002
      |=> s_axi_rresp == base_decode_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read not answered with an error");
  rd_ctrl_a: assert property (ar_hs && s_axi_araddr[11:2] == 10'h000
      |=> s_axi_rdata == {30'h0000_0000, $past(ctrl_q)})
    else $error("Control read returned a wrong value");
  rd_status_a: assert property (ar_hs && s_axi_araddr[11:2] == 10'h001
      |=> s_axi_rdata == {29'h0000_0000, $past(mem_cycle_i), $past(mem_sel_o), $past(io_sel_o)})
    else $error("Status read returned a wrong value");
  rd_switch_a: assert property (ar_hs && s_axi_araddr[11:2] == 10'h002
      |=> s_axi_rdata == {26'h000_0000, $past(switch_i)})
    else $error("Switch read returned a wrong value");

endmodule // base_address_decoder

`default_nettype wire

// ===== include/base_decode_pkg.sv
`default_nettype none
package base_decode_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned MEM_ADDR_W = 20;
  localparam int unsigned IO_ADDR_W  = 16;
  localparam int unsigned DEC_W      = 6;
  localparam int unsigned CODE_W     = 3;
  localparam int unsigned NUM_CODES  = 8;

  // ------------------------------------------------------------
  // Base tables, one six-bit entry per switch code
  // ------------------------------------------------------------
  localparam logic [47:0] IO_BASE_TBL  = {6'h00, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
  localparam logic [7:0]  IO_CODE_EN   = 8'h7f;
  localparam logic [47:0] MEM_BASE_TBL = {6'h00, 6'h00, 6'h00, 6'h38, 6'h30, 6'h28, 6'h20, 6'h18};
  localparam logic [7:0]  MEM_CODE_EN  = 8'h1f;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFS   = 12'h000;
  localparam logic [11:0] STATUS_OFFS = 12'h004;
  localparam logic [11:0] SWITCH_OFFS = 12'h008;
  localparam logic [1:0]  CTRL_RESET  = 2'h3;
  localparam int unsigned CTRL_IO_EN  = 0;
  localparam int unsigned CTRL_MEM_EN = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [CODE_W-1:0] mem_code;
    logic [CODE_W-1:0] io_code;
  } switch_s;

endpackage

`default_nettype wire

// ===== tb/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host side of the expansion bus
// ------------------------------------------------------------
module host_bus_model (
  input  wire logic        clk_i,
  input  wire logic        drive_i,
  input  wire logic [19:0] addr_req_i,
  input  wire logic        mem_req_i,
  output logic      [19:0] addr_o,
  output logic             mem_cycle_o
);
  always_ff @(posedge clk_i) begin
    if (drive_i) begin
      addr_o      <= addr_req_i;
      mem_cycle_o <= mem_req_i;
    end else begin
      addr_o <= ~addr_o;
    end
  end
endmodule // host_bus_model
`default_nettype wire

// ===== tb/tb_base_address_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_base_address_decoder;
  logic                     clk_i, sys_rst_i, drive, mem_req, mem_cycle, io_sel_o, mem_sel_o;
  logic [19:0]              addr_req, addr;
  base_decode_pkg::switch_s sw;
  logic [11:0]              awaddr, araddr;
  logic [31:0]              wdata, rdata, d;
  logic [1:0]               bresp, rresp, r;
  logic [3:0]               strb;
  logic                     awvalid, awready, wvalid, wready, bvalid, bready;
  logic                     arvalid, arready, rvalid, rready;
  int                       n_mismatch, checked;

  host_bus_model host (.clk_i(clk_i), .drive_i(drive), .addr_req_i(addr_req), .mem_req_i(mem_req),
    .addr_o(addr), .mem_cycle_o(mem_cycle));

  base_address_decoder DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .addr_i(addr),
    .mem_cycle_i(mem_cycle), .switch_i(sw), .io_sel_o(io_sel_o), .mem_sel_o(mem_sel_o),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t ns compare mismatch", $time);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk_i);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid;
      rs    = bresp;
      @(posedge clk_i);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_ok, r_ok;
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk_i);
      ar_ok = arvalid && arready;
      r_ok  = rvalid;
      v     = rdata;
      rs    = rresp;
      @(posedge clk_i);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
  endtask

  task automatic sweep(input logic [1:0] en);
    for (int q = 0; q < 2; q++)
      for (int c = 0; c < 8; c++)
        for (int a = 0; a < 64; a++) begin
          @(posedge clk_i);
          sw       <= '{mem_code: c[2:0], io_code: c[2:0]};
          addr_req <= {14'h2a95, a[5:0]};
          mem_req  <= q[0];
          @(posedge clk_i);
          @(negedge clk_i);
          chk(io_sel_o === (en[0] && q == 0 && c < 7 && a == c));
          chk(mem_sel_o === (en[1] && q == 1 && c < 5 && a == 24 + 8 * c));
        end
  endtask

  task automatic probe;
    for (int c = 0; c < 7; c++)
      for (int b = 0; b < 7; b++) begin
        @(posedge clk_i);
        sw       <= '{mem_code: 3'h7, io_code: c[2:0]};
        addr_req <= {4'h9, 10'h155, b[5:0]};
        mem_req  <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(io_sel_o === (b == c) && mem_sel_o === 1'b0);
      end
  endtask

  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end

  initial begin
    sys_rst_i = 1'b1;
    drive = 1'b1;
    strb = 4'hf;
    mem_req = 1'b0;
    addr_req = 20'h00000;
    sw = '0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_mismatch = 0;
    checked = 0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    drive     <= 1'b1;
    axi_rd(base_decode_pkg::CTRL_OFFS, d, r);
    chk(d[1:0] === 2'h3 && r === base_decode_pkg::RESP_OKAY);
    probe();
    sweep(2'h3);
    axi_wr(base_decode_pkg::CTRL_OFFS, 32'h1, r);
    chk(r === base_decode_pkg::RESP_OKAY);
    sweep(2'h1);
    axi_wr(base_decode_pkg::CTRL_OFFS, 32'h2, r);
    chk(r === base_decode_pkg::RESP_OKAY);
    sweep(2'h2);
    axi_wr(12'h00c, 32'h0, r);
    chk(r === base_decode_pkg::RESP_SLVERR);
    axi_rd(12'h00c, d, r);
    chk(d === 32'h0 && r === base_decode_pkg::RESP_SLVERR);
    strb <= 4'h0;
    axi_wr(base_decode_pkg::CTRL_OFFS, 32'h0, r);
    strb <= 4'hf;
    axi_rd(base_decode_pkg::CTRL_OFFS, d, r);
    chk(d[1:0] === 2'h2 && r === base_decode_pkg::RESP_OKAY);
    axi_wr(base_decode_pkg::CTRL_OFFS, 32'h3, r);
    sw       <= '{mem_code: 3'h3, io_code: 3'h3};
    addr_req <= 20'hfffc3;
    mem_req  <= 1'b0;
    axi_rd(base_decode_pkg::STATUS_OFFS, d, r);
    chk(d[2:0] === 3'h1 && r === base_decode_pkg::RESP_OKAY);
    axi_rd(base_decode_pkg::SWITCH_OFFS, d, r);
    chk(d[5:0] === 6'h1b && r === base_decode_pkg::RESP_OKAY);
    end_sim();
  end
endmodule // tb_base_address_decoder
`default_nettype wire
